// ### rtl/ssfs_link.sv
// ==========================================================
// Data line driver on the bus clock
module ssfs_link (
	// Link clock
	input  wire logic scl_clk,
	// Drive request from the system side
	input  wire logic want_low,
	input  wire logic frame_en,
	// Data pin
	output logic      sda_o,
	output logic      sda_oe
);
	typedef struct packed {
		logic drive;
	} ssfs_link_s;

	ssfs_link_s r;
	ssfs_link_s next_r;

	// Request changes only a few clk cycles after a clock rise and then holds,
	// so the falling edge samples a settled level
	always_comb begin
		next_r.drive = want_low;
	end

	// No reset: the clock may stand still, frame_en masks it
	always_ff @(negedge scl_clk) begin
		r <= next_r;
	end

	// Open drain, ended at once by the frame flag
	assign sda_o  = 1'b0;
	assign sda_oe = r.drive & frame_en;
endmodule : ssfs_link

// ### rtl/ssfs_pkg.sv
package ssfs_pkg;

	// ==========================================================
	// Bus addresses
	localparam logic [6:0] DEV_ADDR = 7'h2e;
	localparam logic [6:0] ARA_ADDR = 7'h0c;

	// ==========================================================
	// Register map and reset values
	localparam logic [7:0] REG_FAN_DUTY   = 8'h30;
	localparam logic [7:0] REG_CFG1       = 8'h40;
	localparam logic [7:0] REG_STATUS     = 8'h41;
	localparam logic [7:0] REG_OT_LIMIT   = 8'h6a;
	localparam int         CFG_TO_DIS_BIT = 6;
	localparam logic [7:0] OT_LIMIT_RST   = 8'h64;
	localparam logic [7:0] FAN_DUTY_RST   = 8'h00;
	localparam logic [7:0] FAN_DUTY_FULL  = 8'hff;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_MHZ     = 125;
	localparam int unsigned FAILSAFE_MS = 4600;
	localparam int unsigned TIMEOUT_MS  = 35;
	localparam int unsigned FAILSAFE_CYC = FAILSAFE_MS * 1000 * CLK_MHZ;
	localparam int unsigned TIMEOUT_CYC  = TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int          FS_W = 30;
	localparam int          TO_W = 23;

	// ==========================================================
	// Types
	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_ADDR = 7'h02,
		S_ACK  = 7'h04,
		S_RX   = 7'h08,
		S_TX   = 7'h10,
		S_MACK = 7'h20,
		S_SKIP = 7'h40
	} ssfs_state_e;

	typedef struct packed {
		logic sup;
		logic scl;
		logic sda;
	} ssfs_bus_s;

	// Pin levels of an idle bus; reset value so no false edge follows
	localparam ssfs_bus_s BUS_IDLE = '{sup: 1'b0, scl: 1'b1, sda: 1'b1};

	typedef struct packed {
		logic       full;
		logic [7:0] duty;
	} ssfs_fan_s;

	typedef struct packed {
		ssfs_bus_s s1;
		ssfs_bus_s s2;
	} ssfs_sync_s;

	typedef struct packed {
		ssfs_state_e          state;
		logic [2:0]           bitcnt;
		logic [7:0]           sh;
		logic                 rd;
		logic                 alert_reply_address;
		logic                 hit;
		logic [1:0]           nbytes;
		logic [7:0]           ptr;
		logic                 want_low;
		logic                 frame_en;
		logic [255:0][7:0]    regs;
		logic                 alert;
		logic                 mon;
		ssfs_bus_s            prev;
		logic                 fs_armed;
		logic [FS_W-1:0]      fs_cnt;
		logic                 failsafe;
		logic [TO_W-1:0]      to_cnt;
		ssfs_fan_s            fan;
	} ssfs_core_s;

endpackage : ssfs_pkg

// ### rtl/ssfs_sync.sv
// ==========================================================
// Two-stage synchroniser for the pin levels
module ssfs_sync (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            sys_rst,
	// Pin levels in, stable levels out
	input  wire ssfs_pkg::ssfs_bus_s d,
	output ssfs_pkg::ssfs_bus_s      q
);
	ssfs_pkg::ssfs_sync_s r;
	ssfs_pkg::ssfs_sync_s next_r;

	// Stage one feeds stage two only
	always_comb begin
		next_r.s1 = d;
		next_r.s2 = r.s1;
		// Reset to idle pin levels: a zero here reads as a clock rise
		if (sys_rst) begin
			next_r = '{s1: ssfs_pkg::BUS_IDLE, s2: ssfs_pkg::BUS_IDLE};
		end
	end

	always_ff @(posedge clk) begin
		r <= next_r;
	end

	assign q = r.s2;
endmodule : ssfs_sync

// ### rtl/ssfs_top.sv
// Functional notes
// - Answer to address 0x2e, and to 0x0c while alerting; write first byte is 0x5c.
// - Each byte is eight data bits plus one acknowledge slot.
// - Data changes with clock low; rising data at clock high is stop.
// - Direction fixed by address byte; changing needs a new operation.
// - Writes carry one or two bytes; reads return exactly one byte.
// - First written byte always loads the address pointer.
// - Second written byte goes to the register the pointer selects.
// - Pointer-only write changes no data register.
// - Read returns the register the pointer selects.
// - Send-byte, receive-byte and read-byte protocols are supported.
// - Repeated start begins a fresh operation with an address byte.
// - Monitoring starts on core supply rise or first completed frame to own address.
// - Fan drive is off after reset until programmed or forced.
// - Not addressed within 4.6 s of core supply: fans full speed.
// - Without core supply the startup fail-safe never fires.
// - A host register write leaves fail-safe.
// - Temperature above the overtemperature limit forces fans full.
// - 35 ms without bus activity releases the bus unless disabled.
// - While alerting, answer the alert reply address with own address.
module ssfs_top #(
	parameter int unsigned FAILSAFE_CYCLES = ssfs_pkg::FAILSAFE_CYC,
	parameter int unsigned TIMEOUT_CYCLES  = ssfs_pkg::TIMEOUT_CYC
) (
	// System clock and reset
	input  wire logic                clk,
	input  wire logic                sys_rst,
	// Bus link
	input  wire logic                scl_clk,
	input  wire logic                sda_i,
	output logic                     sda_o,
	output logic                     sda_oe,
	// Supervision inputs
	input  wire logic                processor_core_supply,
	input  wire logic [7:0]          temp_reading,
	input  wire logic                fault,
	// Supervision outputs
	output logic                     alert_oe,
	output logic                     monitor_en,
	output logic                     failsafe,
	output ssfs_pkg::ssfs_fan_s      fan
);
	localparam logic [ssfs_pkg::FS_W-1:0] FS_LAST =
		ssfs_pkg::FS_W'(FAILSAFE_CYCLES - 1);
	localparam logic [ssfs_pkg::TO_W-1:0] TO_LAST =
		ssfs_pkg::TO_W'(TIMEOUT_CYCLES - 1);

	ssfs_pkg::ssfs_core_s r;
	ssfs_pkg::ssfs_core_s next_r;
	ssfs_pkg::ssfs_bus_s  lines;
	logic [7:0]           rx_byte;
	logic                 start_ev;
	logic                 stop_ev;
	logic                 rise_ev;
	logic                 activity;
	logic                 to_hit;
	logic                 addr_hit;
	logic                 wr_done;
	logic                 over_temp;

	// Register read mux; status shows live alert state
	function automatic logic [7:0] reg_read(
		input logic [255:0][7:0] regs,
		input logic [7:0]        idx,
		input logic              alrt,
		input logic              flt
	);
		if (idx == ssfs_pkg::REG_STATUS) begin
			reg_read = {6'h00, flt, alrt};
		end else begin
			reg_read = regs[idx];
		end
	endfunction : reg_read

	// ==========================================================
	// Pin synchronisers and data line driver
	ssfs_sync u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       ('{sup: processor_core_supply, scl: scl_clk, sda: sda_i}),
		.q       (lines)
	);

	ssfs_link u_link (
		.scl_clk  (scl_clk),
		.want_low (r.want_low),
		.frame_en (r.frame_en),
		.sda_o    (sda_o),
		.sda_oe   (sda_oe)
	);

	// ==========================================================
	// Bus events, seen on synchronised lines
	always_comb begin
		rx_byte  = {r.sh[6:0], lines.sda};
		rise_ev  = ~r.prev.scl & lines.scl;
		start_ev = r.prev.scl & lines.scl & r.prev.sda & ~lines.sda;
		stop_ev  = r.prev.scl & lines.scl & ~r.prev.sda & lines.sda;
		activity = (r.prev.scl ^ lines.scl) | (r.prev.sda ^ lines.sda);
		to_hit   = (r.state != ssfs_pkg::S_IDLE) & ~activity
			& (r.to_cnt == TO_LAST)
			& ~r.regs[ssfs_pkg::REG_CFG1][ssfs_pkg::CFG_TO_DIS_BIT];
		over_temp = temp_reading > r.regs[ssfs_pkg::REG_OT_LIMIT];
	end

	// ==========================================================
	// Protocol engine, supervision and register file
	always_comb begin
		next_r   = r;
		addr_hit = 1'b0;
		wr_done  = 1'b0;
		next_r.prev = lines;

		// Idle time counter; stops at its end value
		if (r.state == ssfs_pkg::S_IDLE || activity) begin
			next_r.to_cnt = '0;
		end else if (r.to_cnt != TO_LAST) begin
			next_r.to_cnt = r.to_cnt + 1'b1;
		end

		// A start overrides any state, repeated or not
		if (start_ev) begin
			next_r.state    = ssfs_pkg::S_ADDR;
			next_r.bitcnt   = 3'h0;
			next_r.frame_en = 1'b1;
			next_r.want_low = 1'b0;
			next_r.nbytes   = 2'h0;
			next_r.hit      = 1'b0;
			next_r.alert_reply_address      = 1'b0;
		end else if (stop_ev) begin
			next_r.state    = ssfs_pkg::S_IDLE;
			next_r.frame_en = 1'b0;
			next_r.want_low = 1'b0;
			if (r.hit) begin
				next_r.mon = 1'b1;
			end
		end else if (to_hit) begin
			next_r.state    = ssfs_pkg::S_IDLE;
			next_r.frame_en = 1'b0;
			next_r.want_low = 1'b0;
		end else if (rise_ev) begin
			next_r.bitcnt = r.bitcnt + 3'h1;
			case (r.state)
				ssfs_pkg::S_ADDR: begin
					next_r.sh = rx_byte;
					if (r.bitcnt == 3'h7) begin
						if (rx_byte[7:1] == ssfs_pkg::DEV_ADDR) begin
							addr_hit        = 1'b1;
							next_r.hit      = 1'b1;
							next_r.rd       = rx_byte[0];
							next_r.state    = ssfs_pkg::S_ACK;
							next_r.want_low = 1'b1;
						end else if (rx_byte == {ssfs_pkg::ARA_ADDR, 1'b1}
								&& r.alert) begin
							next_r.alert_reply_address      = 1'b1;
							next_r.rd       = 1'b1;
							next_r.state    = ssfs_pkg::S_ACK;
							next_r.want_low = 1'b1;
						end else begin
							next_r.state    = ssfs_pkg::S_SKIP;
						end
					end
				end
				ssfs_pkg::S_ACK: begin
					// Ninth clock high: pick the next byte's role
					next_r.bitcnt = 3'h0;
					if (r.rd) begin
						next_r.state = ssfs_pkg::S_TX;
						if (r.alert_reply_address) begin
							next_r.sh = {ssfs_pkg::DEV_ADDR, 1'b0};
						end else begin
							next_r.sh = reg_read(r.regs, r.ptr,
								r.alert, fault);
							if (r.ptr == ssfs_pkg::REG_STATUS) begin
								next_r.alert = 1'b0;
							end
						end
						next_r.want_low = ~next_r.sh[7];
					end else begin
						next_r.state    = ssfs_pkg::S_RX;
						next_r.want_low = 1'b0;
					end
				end
				ssfs_pkg::S_RX: begin
					next_r.sh = rx_byte;
					if (r.bitcnt == 3'h7) begin
						next_r.state    = ssfs_pkg::S_ACK;
						next_r.want_low = 1'b1;
						if (r.nbytes == 2'h0) begin
							next_r.ptr = rx_byte;
						end else if (r.nbytes == 2'h1) begin
							next_r.regs[r.ptr] = rx_byte;
							wr_done = 1'b1;
						end else begin
							// A third byte is beyond the write format
							next_r.state    = ssfs_pkg::S_SKIP;
							next_r.want_low = 1'b0;
						end
						if (r.nbytes != 2'h2) begin
							next_r.nbytes = r.nbytes + 2'h1;
						end
					end
				end
				ssfs_pkg::S_TX: begin
					next_r.sh       = {r.sh[6:0], 1'b0};
					next_r.want_low = ~r.sh[6];
					if (r.bitcnt == 3'h7) begin
						next_r.state    = ssfs_pkg::S_MACK;
						next_r.want_low = 1'b0;
					end
				end
				ssfs_pkg::S_MACK: begin
					// Only one byte per read, whatever the master says
					next_r.state    = ssfs_pkg::S_SKIP;
					next_r.want_low = 1'b0;
				end
				default: begin
					next_r.want_low = 1'b0;
				end
			endcase
		end

		// Startup fail-safe window, armed only by the supply edge
		if (lines.sup & ~r.prev.sup) begin
			next_r.fs_armed = 1'b1;
			next_r.fs_cnt   = '0;
			next_r.mon      = 1'b1;
		end else if (r.fs_armed) begin
			if (r.fs_cnt == FS_LAST) begin
				next_r.failsafe = 1'b1;
				next_r.fs_armed = 1'b0;
			end else begin
				next_r.fs_cnt = r.fs_cnt + 1'b1;
			end
		end
		if (addr_hit) begin
			next_r.fs_armed = 1'b0;
		end
		if (wr_done) begin
			next_r.failsafe = 1'b0;
		end

		// Fault sets the alert; setting wins over a clearing read
		if (fault) begin
			next_r.alert = 1'b1;
		end

		// Fan drive from flops; forced full on either cause
		next_r.fan.full = next_r.failsafe | over_temp;
		if (next_r.fan.full) begin
			next_r.fan.duty = ssfs_pkg::FAN_DUTY_FULL;
		end else begin
			next_r.fan.duty = next_r.regs[ssfs_pkg::REG_FAN_DUTY];
		end

		if (sys_rst) begin
			next_r       = '0;
			next_r.state = ssfs_pkg::S_IDLE;
			next_r.prev  = ssfs_pkg::BUS_IDLE;
			next_r.regs[ssfs_pkg::REG_OT_LIMIT] = ssfs_pkg::OT_LIMIT_RST;
			next_r.regs[ssfs_pkg::REG_FAN_DUTY] = ssfs_pkg::FAN_DUTY_RST;
		end
	end

	always_ff @(posedge clk) begin
		r <= next_r;
	end

	// ==========================================================
	// Outputs
	assign alert_oe   = r.alert;
	assign monitor_en = r.mon;
	assign failsafe   = r.failsafe;
	assign fan        = r.fan;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	own_addr_ack_a: assert property (
		r.state == ssfs_pkg::S_ADDR && rise_ev && r.bitcnt == 3'h7
		&& rx_byte[7:1] == ssfs_pkg::DEV_ADDR
		|=> r.state == ssfs_pkg::S_ACK && r.want_low && r.hit)
		else $error("own address not acknowledged");

	foreign_nack_a: assert property (
		r.state == ssfs_pkg::S_ADDR && rise_ev && r.bitcnt == 3'h7
		&& rx_byte[7:1] != ssfs_pkg::DEV_ADDR && !r.alert
		|=> r.state == ssfs_pkg::S_SKIP && !r.want_low)
		else $error("foreign address acknowledged");

	ack_slot_a: assert property (
		r.state == ssfs_pkg::S_ACK |-> r.want_low && r.bitcnt == 3'h0)
		else $error("acknowledge slot not driven low");

	stop_release_a: assert property (
		stop_ev |=> r.state == ssfs_pkg::S_IDLE && !r.frame_en)
		else $error("stop did not release the bus");

	restart_a: assert property (
		start_ev |=> r.state == ssfs_pkg::S_ADDR && r.bitcnt == 3'h0)
		else $error("start did not open a fresh operation");

	ptr_load_a: assert property (
		r.state == ssfs_pkg::S_RX && rise_ev && r.bitcnt == 3'h7
		&& r.nbytes == 2'h0
		|=> r.ptr == $past(rx_byte) && r.regs == $past(r.regs))
		else $error("first write byte not loaded into pointer");

	data_store_a: assert property (
		r.state == ssfs_pkg::S_RX && rise_ev && r.bitcnt == 3'h7
		&& r.nbytes == 2'h1
		|=> r.regs[r.ptr] == $past(rx_byte) && !r.failsafe)
		else $error("second write byte not stored");

	one_read_a: assert property (
		r.state == ssfs_pkg::S_MACK && rise_ev
		|=> r.state == ssfs_pkg::S_SKIP ##1 !r.want_low)
		else $error("more than one byte offered on read");

	fs_cause_a: assert property (
		$rose(r.failsafe) |-> $past(r.fs_armed)
		&& $past(r.fs_cnt) == FS_LAST)
		else $error("fail-safe without an expired window");

	fs_supply_a: assert property (
		$rose(r.fs_armed) |-> r.prev.sup && !$past(r.prev.sup))
		else $error("fail-safe window armed without supply");

	hot_fans_a: assert property (
		over_temp |=> r.fan.full
		&& r.fan.duty == ssfs_pkg::FAN_DUTY_FULL)
		else $error("overtemperature did not force fans");

	idle_drop_a: assert property (
		to_hit && !start_ev && !stop_ev
		|=> r.state == ssfs_pkg::S_IDLE && !r.frame_en)
		else $error("bus not released after idle timeout");

	start_mon_a: assert property (
		stop_ev && r.hit |=> r.mon)
		else $error("completed frame did not start monitoring");

	read_cov: cover property (
		r.state == ssfs_pkg::S_TX ##[1:300] r.state == ssfs_pkg::S_MACK);
	write_cov: cover property (wr_done);
	fs_cov: cover property ($rose(r.failsafe));
	ara_cov: cover property ($rose(r.alert_reply_address));
endmodule : ssfs_top

// ### test/ssfs_host_model.sv
// ==========================================================
// Host bus master: makes the clock, pulls data low
module ssfs_host_model (
	// Bus pins
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int Q = 256; // Quarter bit; 32 clk, lands on falling clk

	// Clock parked high, data released while idle
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// One pulse; data moves mid-low, sampled mid-high
	task automatic pulse(input logic low, output logic seen);
		#Q sda_low = low;
		#Q scl = 1'b1;
		#Q seen = sda;
		#Q scl = 1'b0;
	endtask : pulse

	// Start or repeated start: data falls, clock high
	task automatic start();
		#Q sda_low = 1'b0;
		#Q scl = 1'b1;
		#Q sda_low = 1'b1;
		#Q scl = 1'b0;
	endtask : start

	// Stop: data low first, rises with clock high
	task automatic stop();
		#Q sda_low = 1'b1;
		#Q scl = 1'b1;
		#Q sda_low = 1'b0;
		#Q;
	endtask : stop

	// Eight bits MSB first, slot left open for the slave
	task automatic send(input logic [7:0] b, output logic acked);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			pulse(~b[i], s);
		end
		pulse(1'b0, s);
		acked = ~s;
	endtask : send

	// Eight bits in, then acknowledge or not-acknowledge
	task automatic recv(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			pulse(1'b0, d[i]);
		end
		pulse(~last, s);
	endtask : recv
endmodule : ssfs_host_model

// ### test/ssfs_top_test.sv
module ssfs_top_test;
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================
	// Signals
	localparam int unsigned FS = 2000; // Short fail-safe window
	localparam int unsigned TO = 500;  // Short bus timeout
	localparam logic [7:0] WA = {ssfs_pkg::DEV_ADDR, 1'b0};
	localparam logic [7:0] RA = {ssfs_pkg::DEV_ADDR, 1'b1};
	localparam logic [7:0] AR = {ssfs_pkg::ARA_ADDR, 1'b1};
	logic                clk;
	logic                sys_rst;
	logic                supply;
	logic [7:0]          temp;
	logic                fault;
	logic                scl;
	logic                host_low;
	logic                sda_o;
	logic                sda_oe;
	logic                alert_oe;
	logic                monitor_en;
	logic                failsafe;
	ssfs_pkg::ssfs_fan_s fan;
	logic                sda;
	logic [7:0]          junk;
	int                  bad_count;
	int                  checks;

	// Open-drain data wire with pull-up
	assign sda = ~(host_low | (sda_oe & ~sda_o));

	// ==========================================================
	// Block and host
	ssfs_top #(
		.FAILSAFE_CYCLES(FS),
		.TIMEOUT_CYCLES (TO)
	) ssfs_top_inst (
		.clk                  (clk),
		.sys_rst              (sys_rst),
		.scl_clk              (scl),
		.sda_i                (sda),
		.sda_o                (sda_o),
		.sda_oe               (sda_oe),
		.processor_core_supply(supply),
		.temp_reading         (temp),
		.fault                (fault),
		.alert_oe             (alert_oe),
		.monitor_en           (monitor_en),
		.failsafe             (failsafe),
		.fan                  (fan)
	);
	ssfs_host_model ssfs_host_model_inst (
		.scl    (scl),
		.sda_low(host_low),
		.sda    (sda)
	);

	// System clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ==========================================================
	// Helpers
	task automatic chk(input string w, input logic [8:0] e, g);
		checks++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", w, e, g);
			bad_count++;
		end
	endtask : chk

	task automatic tx(input logic [7:0] b, input logic e);
		logic a;
		ssfs_host_model_inst.send(b, a);
		chk("ack", {8'h00, e}, {8'h00, a});
	endtask : tx

	task automatic rx(input logic [7:0] e);
		logic [7:0] d;
		ssfs_host_model_inst.recv(1'b1, d);
		chk("read", {1'b0, e}, {1'b0, d});
	endtask : rx

	task automatic go();
		ssfs_host_model_inst.start();
	endtask : go

	// Stop, then let the frame end settle
	task automatic halt();
		ssfs_host_model_inst.stop();
		repeat (8) @(negedge clk);
	endtask : halt

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_clk

	task automatic reg_write(input logic [7:0] p, d);
		go();
		tx(WA, 1'b1);
		tx(p, 1'b1);
		tx(d, 1'b1);
		halt();
	endtask : reg_write

	// Pointer set, then new operation to turn direction
	task automatic reg_read(input logic [7:0] p, e);
		go();
		tx(WA, 1'b1);
		tx(p, 1'b1);
		go();
		tx(RA, 1'b1);
		rx(e);
		halt();
	endtask : reg_read

	// Reset, held two cycles, then sync flush
	task automatic do_reset();
		sys_rst = 1'b1;
		wait_clk(2);
		sys_rst = 1'b0;
		wait_clk(4);
		chk("outs", 9'h000, {sda_oe, alert_oe, monitor_en, failsafe, 5'h00});
		chk("fan", 9'h000, fan);
	endtask : do_reset

	// ==========================================================
	// Scenarios
	task automatic t_data();
		go();
		tx({ssfs_pkg::DEV_ADDR ^ 7'h01, 1'b0}, 1'b0);
		halt();
		go();
		tx(AR, 1'b0);
		halt();
		reg_write(ssfs_pkg::REG_FAN_DUTY, 8'h80);
		chk("duty", 9'h080, fan);
		chk("mon", 9'h001, {8'h00, monitor_en});
		reg_read(ssfs_pkg::REG_FAN_DUTY, 8'h80);
		go();
		tx(RA, 1'b1);
		rx(8'h80);
		halt();
		// Master acknowledges, yet only one byte comes back
		go();
		tx(RA, 1'b1);
		ssfs_host_model_inst.recv(1'b0, junk);
		chk("acked", 9'h080, {1'b0, junk});
		rx(8'hff);
		halt();
		go();
		tx(WA, 1'b1);
		tx(ssfs_pkg::REG_OT_LIMIT, 1'b1);
		halt();
		go();
		tx(RA, 1'b1);
		rx(ssfs_pkg::OT_LIMIT_RST);
		halt();
		chk("duty", 9'h080, fan);
		go();
		tx(WA, 1'b1);
		tx(ssfs_pkg::REG_FAN_DUTY, 1'b1);
		tx(8'h40, 1'b1);
		tx(8'h11, 1'b0);
		halt();
		chk("duty", 9'h040, fan);
		wait_clk(FS + 50);
		chk("fs", 9'h000, {8'h00, failsafe});
	endtask : t_data

	task automatic t_overtemp();
		temp = 8'h65;
		wait_clk(4);
		chk("hot", 9'h1ff, fan);
		temp = 8'h64;
		wait_clk(4);
		chk("edge", 9'h040, fan);
		reg_write(ssfs_pkg::REG_OT_LIMIT, 8'h70);
		temp = 8'h65;
		wait_clk(4);
		chk("limit", 9'h040, fan);
		temp = 8'h20;
	endtask : t_overtemp

	task automatic t_alert();
		fault = 1'b1;
		wait_clk(4);
		chk("alert", 9'h001, {8'h00, alert_oe});
		go();
		tx(AR, 1'b1);
		rx(WA);
		halt();
		fault = 1'b0;
		reg_read(ssfs_pkg::REG_STATUS, 8'h01);
		chk("clear", 9'h000, {8'h00, alert_oe});
	endtask : t_alert

	// Read stalled while the block drives a zero bit
	task automatic t_timeout();
		go();
		tx(RA, 1'b1);
		wait_clk(10);
		chk("drive", 9'h001, {8'h00, sda_oe});
		wait_clk(TO + 50);
		chk("release", 9'h000, {8'h00, sda_oe});
		ssfs_host_model_inst.recv(1'b1, junk);
		halt();
		reg_write(ssfs_pkg::REG_CFG1, 8'h40);
		go();
		tx(WA, 1'b1);
		tx(ssfs_pkg::REG_STATUS, 1'b1);
		go();
		tx(RA, 1'b1);
		wait_clk(TO + 50);
		chk("held", 9'h001, {8'h00, sda_oe});
		rx(8'h00);
		halt();
	endtask : t_timeout

	task automatic t_failsafe();
		do_reset();
		supply = 1'b1;
		wait_clk(6);
		chk("mon", 9'h001, {8'h00, monitor_en});
		// Addressed inside the window: no fail-safe
		go();
		tx(RA, 1'b1);
		rx(8'h00);
		halt();
		wait_clk(FS + 20);
		chk("early", 9'h000, {7'h00, failsafe, fan.full});
		// Fresh supply edge, then left unaddressed
		supply = 1'b0;
		wait_clk(4);
		supply = 1'b1;
		wait_clk(FS + 26);
		chk("fs", 9'h003, {7'h00, failsafe, fan.full});
		reg_write(ssfs_pkg::REG_FAN_DUTY, 8'h20);
		chk("leave", 9'h000, {8'h00, failsafe});
		chk("duty", 9'h020, fan);
	endtask : t_failsafe

	// ==========================================================
	// Verdict
	task automatic finish_test();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test

	// Main sequence, supply held low until the last scenario
	initial begin
		bad_count = 0;
		checks = 0;
		sys_rst = 1'b1;
		supply = 1'b0;
		temp = 8'h20;
		fault = 1'b0;
		do_reset();
		t_data();
		t_overtemp();
		t_alert();
		t_timeout();
		t_failsafe();
		finish_test();
	end

	// Watchdog well past the expected run
	initial begin
		#700000;
		bad_count++;
		finish_test();
	end
endmodule : ssfs_top_test
